// >>> rtl/borl_pkg.sv
// package: constants and types for the binary output relay channel
// Functional notes
// R01: mode selects working-current or closed-circuit energizing
// R02: new output state held for hold time
// R03: latching keeps channel picked up until acknowledged
// R04: selectable internal signal acknowledges latched channel
// R05: acknowledge ignored while latching disabled
// R06: overall inversion inverts resulting relay state
// R07: per-input inversion before combining
// R08: inputs ORed, deassertion delayed by off delay
package borl_pkg;
  localparam int BORL_CLK_HZ = 125000000;
  localparam int BORL_TICK_MS = 10; // settings are in 0.01 s steps
  localparam int BORL_CYC_PER_TICK = BORL_CLK_HZ / 1000 * BORL_TICK_MS;
  localparam int BORL_TIME_MAX_TICKS = 30000; // 300.00 s
  localparam int BORL_TIME_W = 15;
  localparam int BORL_NUM_ASSIGN = 5;
  localparam int BORL_SEL_W = 4;
  localparam logic [BORL_TIME_W-1:0] BORL_HOLD_RST = 15'h0000;
  localparam logic [BORL_TIME_W-1:0] BORL_OFFDLY_RST = 15'h0000;
  localparam logic BORL_INV_RST = 1'h0;
  localparam logic BORL_MODE_WORKING = 1'h0;
  localparam logic BORL_MODE_CLOSED = 1'h1;
  localparam logic BORL_LATCH_SLOT_FIRST = 1'h1;
  localparam logic BORL_LATCH_SLOT_SECOND = 1'h0;

  typedef enum logic [2:0] {
    BORL_ST_OFF = 3'h1,
    BORL_ST_ON = 3'h2,
    BORL_ST_DELAY = 3'h4
  } borl_state_t;
endpackage

// >>> rtl/borl_tick_if.sv
// interface: time-base tick shared between the tick generator and the channel
`timescale 1ns/1ps
interface borl_tick_if;
  logic tick;
  modport source (output tick);
  modport sink (input tick);
endinterface

// >>> rtl/borl_tick_gen.sv
// module: 10 ms tick generator for the channel timers
`timescale 1ns/1ps
module borl_tick_gen
  import borl_pkg::*;
#(
  parameter int CYC_PER_TICK = BORL_CYC_PER_TICK
) (
  input wire logic i_clk,
  input wire logic i_reset,
  borl_tick_if.source tick_bus
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic tick_reg;
  wire logic wrap = (cnt_reg == 32'(CYC_PER_TICK - 1));

  assign cnt_next = wrap ? 32'h0 : cnt_reg + 32'h1;
  assign tick_bus.tick = tick_reg;

  // free-running divider; one-cycle pulse per tick
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_reg <= 32'h0;
      tick_reg <= 1'h0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= wrap;
    end
  end
endmodule

// >>> rtl/borl_channel.sv
// module: one binary output relay channel with hold, off delay, latch and inversion
`timescale 1ns/1ps
module borl_channel
  import borl_pkg::*;
#(
  parameter int NUM_ASSIGN = BORL_NUM_ASSIGN,
  parameter int SEL_W = BORL_SEL_W,
  parameter int CYC_PER_TICK = BORL_CYC_PER_TICK,
  parameter logic LATCH_DEFAULT = BORL_LATCH_SLOT_FIRST
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [(1<<SEL_W)-1:0] i_signals,
  input wire logic [NUM_ASSIGN-1:0] i_assign_en,
  input wire logic [NUM_ASSIGN*SEL_W-1:0] i_assign_sel,
  input wire logic [NUM_ASSIGN-1:0] i_assign_invert,
  input wire logic i_mode_closed_circuit,
  input wire logic [BORL_TIME_W-1:0] i_hold_time,
  input wire logic [BORL_TIME_W-1:0] i_off_delay,
  input wire logic i_latch_enable,
  input wire logic i_latch_override,
  input wire logic i_ack_en,
  input wire logic [SEL_W-1:0] i_ack_sel,
  input wire logic i_out_invert,
  output logic o_relay_coil,
  output logic o_channel_state,
  output logic o_latched,
  output logic o_hold_active
);
  borl_tick_if tick_bus ();

  borl_tick_gen #(
    .CYC_PER_TICK(CYC_PER_TICK)
  ) u_tick (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .tick_bus(tick_bus)
  );

  // pick one signal out of the internal signal list
  function automatic logic sel_bit(input logic [(1<<SEL_W)-1:0] vec, input logic [SEL_W-1:0] idx);
    sel_bit = vec[idx];
  endfunction

  // latch enable default depends on card slot; override input chooses the setting
  wire logic latch_on = i_latch_override ? i_latch_enable : LATCH_DEFAULT;

  // combine assignments: unassigned inputs count as inactive
  logic combined;
  always_comb begin
    combined = 1'b0;
    for (int k = 0; k < NUM_ASSIGN; k++) begin
      if (i_assign_en[k]) begin
        combined = combined | (sel_bit(i_signals, i_assign_sel[k*SEL_W +: SEL_W]) ^ i_assign_invert[k]); // R07 R08
      end
    end
  end

  // ack only counts while latching is on
  wire logic ack = latch_on & i_ack_en & sel_bit(i_signals, i_ack_sel); // R04 R05

  borl_state_t state_reg;
  borl_state_t state_next;
  logic [BORL_TIME_W-1:0] off_cnt_reg;
  logic [BORL_TIME_W-1:0] off_cnt_next;
  logic latch_reg;
  logic latch_next;
  logic [BORL_TIME_W-1:0] hold_cnt_reg;
  logic [BORL_TIME_W-1:0] hold_cnt_next;
  logic out_reg;
  logic out_next;
  logic coil_reg;
  logic hold_reg;

  wire logic tick = tick_bus.tick;
  wire logic delayed_on = (state_reg != BORL_ST_OFF);

  // off-delay state machine: pickup is immediate, dropout waits the off delay
  always_comb begin
    state_next = state_reg;
    off_cnt_next = off_cnt_reg;
    unique case (state_reg)
      BORL_ST_OFF: begin
        if (combined) begin
          state_next = BORL_ST_ON;
        end
      end
      BORL_ST_ON: begin
        if (!combined) begin
          off_cnt_next = '0;
          state_next = (i_off_delay == '0) ? BORL_ST_OFF : BORL_ST_DELAY; // R08
        end
      end
      BORL_ST_DELAY: begin
        if (combined) begin
          state_next = BORL_ST_ON;
        end else if (tick) begin
          off_cnt_next = off_cnt_reg + 15'h1;
          if (off_cnt_reg + 15'h1 >= i_off_delay) begin
            state_next = BORL_ST_OFF; // R08
          end
        end
      end
      default: state_next = BORL_ST_OFF;
    endcase
  end

  // latch sets on pickup; a new pickup beats a simultaneous ack
  assign latch_next = latch_on & ((delayed_on & out_reg) | (latch_reg & ~ack)); // R03 R05

  // requested state before hold: latched channel stays picked up
  wire logic want = delayed_on | latch_next; // R03
  wire logic hold_busy = (hold_cnt_reg != '0);

  // hold timer: a change is only accepted once the previous state was held long enough
  always_comb begin
    out_next = out_reg;
    hold_cnt_next = hold_cnt_reg;
    if (hold_busy) begin
      if (tick) begin
        hold_cnt_next = hold_cnt_reg - 15'h1; // R02
      end
    end else if (want != out_reg) begin
      out_next = want;
      hold_cnt_next = i_hold_time; // R02
    end
  end

  // energizing principle then overall inversion
  wire logic coil_next = (out_next ^ i_out_invert) ^ (i_mode_closed_circuit == BORL_MODE_CLOSED); // R01 R06

  // state registers; outputs stay registered for glitch-free coil drive
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= BORL_ST_OFF;
      off_cnt_reg <= '0;
      latch_reg <= 1'b0;
      hold_cnt_reg <= BORL_HOLD_RST;
      out_reg <= 1'b0;
      coil_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      off_cnt_reg <= off_cnt_next;
      latch_reg <= latch_next;
      hold_cnt_reg <= hold_cnt_next;
      out_reg <= out_next;
      coil_reg <= coil_next;
      hold_reg <= (hold_cnt_next != '0);
    end
  end

  assign o_relay_coil = coil_reg;
  assign o_channel_state = out_reg;
  assign o_latched = latch_reg;
  assign o_hold_active = hold_reg;
endmodule

// >>> tb/borl_relay_model.sv
// partner: relay armature whose contact follows the coil
`timescale 1ns/1ps
module borl_relay_model (
  input wire logic i_clk,
  input wire logic i_coil,
  output logic o_contact
);
  logic [1:0] arm_reg = 2'h0;
  // mechanics lag the coil by two cycles, so checks must let the contact settle
  always_ff @(posedge i_clk) arm_reg <= {arm_reg[0], i_coil};
  assign o_contact = arm_reg[1];
endmodule

// >>> tb/borl_chk_props.sv
// checker: port assertions for one relay channel
`timescale 1ns/1ps
module borl_chk_props #(parameter logic LATCH_DEFAULT = 1'h1) (
  input wire logic i_clk, i_reset, i_mode_closed_circuit, i_latch_enable, i_latch_override, i_ack_en,
  input wire logic i_out_invert, o_relay_coil, o_channel_state, o_latched, o_hold_active,
  input wire logic [15:0] i_signals,
  input wire logic [4:0] i_assign_en, i_assign_invert,
  input wire logic [19:0] i_assign_sel,
  input wire logic [14:0] i_hold_time, i_off_delay,
  input wire logic [3:0] i_ack_sel
);
  logic comb;
  wire lat_on = i_latch_override ? i_latch_enable : LATCH_DEFAULT;
  wire ack = lat_on & i_ack_en & i_signals[i_ack_sel];
  // reference OR of assigned signals, each after its own inversion
  always_comb begin
    comb = 1'h0;
    for (int k = 0; k < 5; k++) comb |= i_assign_en[k] & (i_signals[i_assign_sel[4*k+:4]] ^ i_assign_invert[k]);
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_coil_polarity: assert property (!$past(i_reset) && $stable({i_mode_closed_circuit, i_out_invert}) |->
    o_relay_coil == (o_channel_state ^ i_mode_closed_circuit ^ i_out_invert)) else $error("coil");
  a_or_pickup: assert property (comb && !o_hold_active && i_hold_time == 15'h0 |-> ##2 o_channel_state)
    else $error("pickup");
  a_drop_nodelay: assert property (!comb && !lat_on && !o_hold_active && i_off_delay == 15'h0 |->
    ##[1:2] !o_channel_state) else $error("dropout");
  a_hold_stable: assert property ($changed(o_channel_state) && i_hold_time == 15'h3 |=>
    $stable(o_channel_state) [*8]) else $error("hold");
  a_hold_starts: assert property ($changed(o_channel_state) && i_hold_time != 15'h0 |-> o_hold_active)
    else $error("hold flag");
  a_latch_on: assert property ($past(o_latched) && o_latched |-> o_channel_state) else $error("latch");
  a_ack_release: assert property (o_latched && ack && !comb |-> ##[1:3] !o_latched) else $error("ack");
  a_ack_ignored: assert property (!lat_on && $stable(lat_on) |-> !o_latched) else $error("no latch");
endmodule
bind borl_channel borl_chk_props #(.LATCH_DEFAULT(LATCH_DEFAULT)) i_borl_chk_props (.*);

// >>> tb/tb_top.sv
// bench: random OR checks, then latch, hold and off-delay sequences
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'h0, i_reset = 1'h1, i_mode_closed_circuit, i_out_invert, i_latch_enable = 1'h0, contact, e;
  logic i_ack_en = 1'h1, i_latch_override = 1'h1, o_relay_coil, o_channel_state, o_latched, o_hold_active;
  logic [15:0] i_signals = 16'h0;
  logic [4:0] i_assign_en, i_assign_invert;
  logic [19:0] i_assign_sel = 20'h0;
  logic [14:0] i_hold_time = 15'h0, i_off_delay = 15'h0;
  logic [3:0] i_ack_sel = 4'hf;
  logic [4:0] exp_q[$];
  int err_total = 0, samples_checked = 0, seed = 20;
  event chk;
  always #4 i_clk = ~i_clk;
  borl_channel #(.CYC_PER_TICK(4)) i_borl_channel (.*);
  borl_relay_model i_borl_relay_model (.i_clk(i_clk), .i_coil(o_relay_coil), .o_contact(contact));
  task automatic cyc(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // note contact, coil, state, latch and hold flag, then let the watcher compare
  task automatic note(logic s, logic l = 1'h0, logic h = 1'h0);
    exp_q.push_back({s ^ i_mode_closed_circuit ^ i_out_invert, s ^ i_mode_closed_circuit ^ i_out_invert, s, l, h});
    -> chk;
    cyc(1);
  endtask
  always @(chk) begin
    samples_checked++;
    if ({contact, o_relay_coil, o_channel_state, o_latched, o_hold_active} !== exp_q[0]) begin
      err_total++;
      $display("wrong value contact_coil_state_latch_hold expected %b seen %b", exp_q[0],
        {contact, o_relay_coil, o_channel_state, o_latched, o_hold_active});
    end
    void'(exp_q.pop_front());
  end
  // pulse slot 0, check it is still on, then pulse the ack source and check it is off
  task automatic seq(logic [14:0] h, logic [14:0] d, logic l, int w);
    i_hold_time = h;
    i_off_delay = d;
    i_latch_enable = l;
    i_signals = 16'h1;
    cyc(4);
    i_signals = 16'h0;
    cyc(w);
    note(1'h1, l, h != 15'h0);
    // ack source pulses in every sequence; without latching it must change nothing
    i_signals = 16'h8000;
    cyc(24);
    note(1'h0);
    i_signals = 16'h0;
    cyc(24);
    $display("sequence done");
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog well past the few hundred cycles the tests need
  initial begin
    #20000;
    err_total++;
    give_verdict();
  end
  initial begin
    {i_mode_closed_circuit, i_out_invert, i_assign_en, i_assign_invert} = 12'h0;
    cyc(20);
    i_reset = 1'h0;
    repeat (20) begin
      {i_mode_closed_circuit, i_out_invert, i_assign_en, i_assign_invert} = 12'($random(seed));
      i_signals = 16'($random(seed));
      i_assign_sel = 20'($random(seed));
      cyc(4);
      e = 1'h0;
      for (int k = 0; k < 5; k++) e |= i_assign_en[k] & (i_signals[i_assign_sel[4*k+:4]] ^ i_assign_invert[k]);
      note(e);
    end
    $display("random done");
    {i_mode_closed_circuit, i_out_invert, i_assign_en, i_assign_invert} = 12'h020;
    i_assign_sel = 20'h0;
    cyc(8);
    seq(15'h0, 15'h0, 1'h1, 4);
    seq(15'h3, 15'h0, 1'h0, 3);
    seq(15'h0, 15'h3, 1'h0, 2);
    give_verdict();
  end
endmodule
